// ==== design/nvac_byte_mem.v ====
// Purpose: Byte-wide data memory array with registered read data.
// Assumes: Single port, one access per clock.
// Notes:   Contents are not cleared by reset, as in a real array.
`timescale 1ns/10ps
`default_nettype none

module nvac_byte_mem #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire mclk_i,
  input wire we_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] wdata_i,
  output reg [DW-1:0] rdata_o
);

  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  always @(posedge mclk_i)
  begin
    if (we_i)
    begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end

endmodule

`default_nettype wire

// ==== design/nvac_ctrl.v ====
// Purpose: APB-reached controller for the data EEPROM and program Flash reads.
// Assumes: Program Flash is a synchronous array outside, read data one cycle
//          after the address; external resets are already synchronised.
// Notes:   Data EEPROM array lives in nvac_byte_mem.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "nvac_map.vh"

module nvac_ctrl #(
  parameter DATA_AW = 8,
  parameter WRITE_CYC = `NVAC_WRITE_CYC
) (
  input wire mclk_i,
  input wire reset_i,
  input wire por_i,
  input wire ext_reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire prog_port_req_i,
  output wire prog_port_block_o,
  output wire [11:0] flash_addr_o,
  output wire flash_rd_o,
  input wire [13:0] flash_data_i,
  output wire busy_o,
  output wire write_done_o
);

  // ----------------------------------------
  // State and registers
  // ----------------------------------------
  localparam ST_IDLE = 5'b00001;
  localparam ST_DRD = 5'b00010;
  localparam ST_PRD = 5'b00100;
  localparam ST_ERASE = 5'b01000;
  localparam ST_PROG = 5'b10000;

  localparam [31:0] ERASE_CYC = WRITE_CYC / `NVAC_ERASE_FRAC;

  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [7:0] data_lo_q;
  reg [5:0] data_hi_q;
  reg [7:0] addr_lo_q;
  reg [3:0] addr_hi_q;
  reg pgd_q;
  reg wallow_q;
  reg wabort_q;
  reg rd_q;
  reg wr_q;
  reg done_q;
  reg cp_q;
  reg [1:0] unlock_q;
  reg [31:0] tmr_q;
  reg [7:0] wbyte_q;
  reg [1:0] req_sync_q;

  wire [7:0] mem_rdata;
  wire mem_we;
  wire [7:0] mem_wdata;
  wire [DATA_AW-1:0] mem_addr;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire acc = psel_i & penable_i;
  wire wacc = acc & pwrite_i;
  wire mapped = (paddr_i[11:5] == 7'h00) && (paddr_i[1:0] == 2'b00);
  wire w_dlo = wacc && paddr_i == `NVAC_OFF_DATA_LO;
  wire w_dhi = wacc && paddr_i == `NVAC_OFF_DATA_HI;
  wire w_alo = wacc && paddr_i == `NVAC_OFF_ADDR_LO;
  wire w_ahi = wacc && paddr_i == `NVAC_OFF_ADDR_HI;
  wire w_ctl = wacc && paddr_i == `NVAC_OFF_CTRL;
  wire w_unl = wacc && paddr_i == `NVAC_OFF_UNLOCK;
  wire w_flg = wacc && paddr_i == `NVAC_OFF_FLAGS;
  wire w_prt = wacc && paddr_i == `NVAC_OFF_PROT;
  wire writing = (state_q == ST_ERASE) || (state_q == ST_PROG);
  wire idle = (state_q == ST_IDLE);

  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;

  wire rd_go = w_ctl & pwdata_i[`NVAC_CTRL_RD] & idle & ~rd_q;
  // Unlock pair must directly precede the write start
  wire wr_go = w_ctl & pwdata_i[`NVAC_CTRL_WR] & idle & ~pwdata_i[`NVAC_CTRL_RD]
               & wallow_q & (unlock_q == 2'b10) & ~pgd_q;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (rd_go)
        begin
          state_d = pwdata_i[`NVAC_CTRL_PGD] ? ST_PRD : ST_DRD;
        end
        else if (wr_go)
        begin
          state_d = ST_ERASE;
        end
      end
      ST_DRD: state_d = ST_IDLE;
      ST_PRD: state_d = ST_IDLE;
      // Internal timer paces erase then program
      ST_ERASE:
      begin
        if (tmr_q == 32'h00000000)
        begin
          state_d = ST_PROG;
        end
      end
      ST_PROG:
      begin
        if (tmr_q == 32'h00000000)
        begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Reduced variant uses a narrower address
  assign mem_addr = writing ? wbyte_q[DATA_AW-1:0] : addr_lo_q[DATA_AW-1:0];
  // Erase writes all ones, then the new byte is programmed
  assign mem_we = ((state_q == ST_ERASE) || (state_q == ST_PROG)) && (tmr_q == 32'h00000000);
  assign mem_wdata = (state_q == ST_ERASE) ? 8'hFF : data_lo_q;
  // Flash gets only address and read strobe, never a write path
  assign flash_addr_o = {addr_hi_q, addr_lo_q};
  assign flash_rd_o = rd_go & pwdata_i[`NVAC_CTRL_PGD];
  // Only the external programmer is locked out
  assign prog_port_block_o = cp_q & req_sync_q[1];
  assign busy_o = wr_q;
  assign write_done_o = done_q;

  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q <= ST_IDLE;
      tmr_q <= 32'h00000000;
      wbyte_q <= `NVAC_RST_BYTE;
    end
    else
    begin
      state_q <= state_d;
      if (idle && wr_go)
      begin
        tmr_q <= ERASE_CYC - 32'h00000001;
        wbyte_q <= addr_lo_q;
      end
      else if (state_q == ST_ERASE && tmr_q == 32'h00000000)
      begin
        tmr_q <= WRITE_CYC - ERASE_CYC - 32'h00000001;
      end
      else if (tmr_q != 32'h00000000)
      begin
        tmr_q <= tmr_q - 32'h00000001;
      end
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      data_lo_q <= `NVAC_RST_BYTE;
      data_hi_q <= 6'h00;
      addr_lo_q <= `NVAC_RST_BYTE;
      addr_hi_q <= 4'h0;
      pgd_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      unlock_q <= 2'b00;
      cp_q <= 1'b0;
      req_sync_q <= 2'b00;
    end
    else
    begin
      if (w_dlo)
      begin
        data_lo_q <= pwdata_i[7:0];
      end
      if (w_dhi)
      begin
        data_hi_q <= pwdata_i[5:0];
      end
      if (w_alo && !writing)
      begin
        addr_lo_q <= pwdata_i[7:0];
      end
      if (w_ahi && !writing)
      begin
        addr_hi_q <= pwdata_i[3:0];
      end
      if (w_ctl && !writing)
      begin
        pgd_q <= pwdata_i[`NVAC_CTRL_PGD];
      end
      if (w_prt)
      begin
        cp_q <= pwdata_i[`NVAC_PROT_CP];
      end
      // Programmer request is a pin: two stages, only the second is read
      req_sync_q <= {req_sync_q[0], prog_port_req_i};
      // Read data captured one cycle after the start
      if (state_q == ST_DRD)
      begin
        data_lo_q <= mem_rdata;
      end
      if (state_q == ST_PRD)
      begin
        // Fourteen-bit word split over the data pair
        data_lo_q <= flash_data_i[7:0];
        data_hi_q <= flash_data_i[13:8];
      end
      // Set by software only, cleared by hardware
      rd_q <= rd_go;
      if (wr_go)
      begin
        wr_q <= 1'b1;
      end
      else if (state_q == ST_PROG && tmr_q == 32'h00000000)
      begin
        wr_q <= 1'b0;
      end
      // Any other access breaks the unlock sequence
      if (w_unl && unlock_q == 2'b00 && pwdata_i[7:0] == `NVAC_KEY_ONE)
      begin
        unlock_q <= 2'b01;
      end
      else if (w_unl && unlock_q == 2'b01 && pwdata_i[7:0] == `NVAC_KEY_TWO)
      begin
        unlock_q <= 2'b10;
      end
      else if (acc)
      begin
        unlock_q <= 2'b00;
      end
    end
  end

  // Write-allow and aborted flag survive external resets; power-up is the only reset that clears them
  always @(posedge mclk_i or posedge por_i)
  begin
    if (por_i)
    begin
      wallow_q <= 1'b0;
      wabort_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      if (w_ctl)
      begin
        wallow_q <= pwdata_i[`NVAC_CTRL_WALLOW];
      end
      // Reset during a write marks it aborted; set beats clear
      if (ext_reset_i && wr_q)
      begin
        wabort_q <= 1'b1;
      end
      else if (w_ctl && !pwdata_i[`NVAC_CTRL_WABORT])
      begin
        wabort_q <= 1'b0;
      end
      // Sticky completion flag; set beats clear
      if (state_q == ST_PROG && tmr_q == 32'h00000000)
      begin
        done_q <= 1'b1;
      end
      else if (w_flg && !pwdata_i[`NVAC_FLAG_DONE])
      begin
        done_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @*
  begin
    prdata_o = 32'h00000000;
    case (paddr_i)
      `NVAC_OFF_DATA_LO: prdata_o[7:0] = data_lo_q;
      `NVAC_OFF_DATA_HI: prdata_o[5:0] = data_hi_q;
      `NVAC_OFF_ADDR_LO: prdata_o[7:0] = addr_lo_q;
      `NVAC_OFF_ADDR_HI: prdata_o[3:0] = addr_hi_q;
      `NVAC_OFF_CTRL: prdata_o[7:0] = {pgd_q, 3'b000, wabort_q, wallow_q, wr_q, rd_q};
      `NVAC_OFF_UNLOCK: prdata_o = 32'h00000000;
      `NVAC_OFF_FLAGS: prdata_o[0] = done_q;
      `NVAC_OFF_PROT: prdata_o[0] = cp_q;
      default: prdata_o = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Data EEPROM array
  // ----------------------------------------
  // Array reached only through this controller
  nvac_byte_mem #(
    .AW(DATA_AW),
    .DW(8)
  ) u_mem (
    .mclk_i(mclk_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // Flash spans 4K words through the twelve-bit address
endmodule

`default_nettype wire

// ==== include/nvac_map.vh ====
// Purpose: Register offsets, field positions, reset values and timing counts
//          for the nonvolatile memory access controller.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef NVAC_MAP_VH
`define NVAC_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define NVAC_OFF_DATA_LO 12'h000
`define NVAC_OFF_DATA_HI 12'h004
`define NVAC_OFF_ADDR_LO 12'h008
`define NVAC_OFF_ADDR_HI 12'h00C
`define NVAC_OFF_CTRL 12'h010
`define NVAC_OFF_UNLOCK 12'h014
`define NVAC_OFF_FLAGS 12'h018
`define NVAC_OFF_PROT 12'h01C

// ----------------------------------------
// Control, flag and protection register fields
// ----------------------------------------
`define NVAC_CTRL_RD 0
`define NVAC_CTRL_WR 1
`define NVAC_CTRL_WALLOW 2
`define NVAC_CTRL_WABORT 3
`define NVAC_CTRL_PGD 7
`define NVAC_FLAG_DONE 0
`define NVAC_PROT_CP 0

// ----------------------------------------
// Reset values and unlock keys
// ----------------------------------------
`define NVAC_RST_BYTE 8'h00
`define NVAC_KEY_ONE 8'h55
`define NVAC_KEY_TWO 8'hAA

// ----------------------------------------
// Timing
// ----------------------------------------
`define NVAC_CLK_NS 10
`define NVAC_WRITE_US 5000
`define NVAC_WRITE_CYC ((`NVAC_WRITE_US * 1000) / `NVAC_CLK_NS)
`define NVAC_ERASE_FRAC 2

`endif

// ==== tb/nvac_ctrl_monitor.sv ====
// Purpose: Port checks for the nonvolatile access controller.
// Assumes: Zero wait APB slave.
// Notes: Bound to every controller instance.
`timescale 1ns/10ps
`default_nettype none
module nvac_ctrl_monitor #(
  parameter WRITE_CYC = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire logic ext_reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic prog_port_req_i,
  input wire logic prog_port_block_o,
  input wire logic [11:0] flash_addr_o,
  input wire logic flash_rd_o,
  input wire logic [13:0] flash_data_i,
  input wire logic busy_o,
  input wire logic write_done_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wire acc = psel_i && penable_i;
  sequence busy_run;
    busy_o [*4];
  endsequence
  ready_high_a:
    assert property (pready_o) else $error("pready low");
  unmapped_err_a:
    assert property (acc && paddr_i > 12'h01C |-> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped access not refused");
  unlock_zero_a:
    assert property (acc && !pwrite_i && paddr_i == 12'h014 |-> prdata_o == 32'h0)
      else $error("unlock port not zero");
  addr_hi_a:
    assert property (acc && paddr_i == 12'h00C |-> prdata_o[31:4] == 28'h0)
      else $error("address high upper bits set");
  data_hi_a:
    assert property (acc && paddr_i == 12'h004 |-> prdata_o[31:6] == 26'h0)
      else $error("data high upper bits set");
  block_req_a:
    assert property (!$past(prog_port_req_i, 2) |-> !prog_port_block_o)
      else $error("block without request");
  rd_pulse_a:
    assert property (flash_rd_o |=> !flash_rd_o) else $error("flash read too long");
  write_start_a:
    assert property ($rose(busy_o) |-> $past(acc && pwrite_i && paddr_i == 12'h010
      && pwdata_i[1])) else $error("write began without start");
  write_time_a:
    assert property ($rose(busy_o) |-> busy_run ##[1:20] !busy_o) else $error("write length");
  done_set_a:
    assert property ($fell(busy_o) && !ext_reset_i |-> write_done_o) else $error("no done");
  done_hold_a:
    assert property (write_done_o && !(acc && pwrite_i && paddr_i == 12'h018) |=> write_done_o)
      else $error("done dropped");
endmodule
bind nvac_ctrl nvac_ctrl_monitor #(.WRITE_CYC(WRITE_CYC)) u_mon (.mclk_i(mclk_i),
  .reset_i(reset_i), .por_i(por_i), .ext_reset_i(ext_reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .prog_port_req_i(prog_port_req_i), .prog_port_block_o(prog_port_block_o),
  .flash_addr_o(flash_addr_o), .flash_rd_o(flash_rd_o), .flash_data_i(flash_data_i),
  .busy_o(busy_o), .write_done_o(write_done_o));
`default_nettype wire

// ==== tb/nvac_flash_model.sv ====
// Purpose: Program flash stand-in answering one-word reads.
// Assumes: Word valid the cycle after the read strobe.
// Notes: Between reads the word flips every cycle so stale data shows.
`timescale 1ns/10ps
`default_nettype none
module nvac_flash_model (
  input wire logic mclk_i,
  input wire logic rd_i,
  input wire logic [11:0] addr_i,
  output logic [13:0] data_o
);
  initial data_o = 14'h0000;
  always @(posedge mclk_i)
    data_o <= rd_i ? ({addr_i, 2'h3} ^ 14'h1234) : ~data_o;
endmodule
`default_nettype wire

// ==== tb/test_nvac_ctrl.sv ====
// Purpose: Register level test of the nonvolatile access controller.
// Assumes: Write time shortened to 8 cycles.
// Notes: Every access goes through the APB task.
`timescale 1ns/10ps
`default_nettype none
module test_nvac_ctrl;
  logic mclk_i = 0, reset_i = 1, por_i = 1, ext_reset_i = 0, prog_port_req_i = 0;
  logic psel_i = 0, penable_i = 0, pwrite_i = 0, slv;
  logic [11:0] paddr_i = 12'h000, flash_addr_o;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rdv;
  logic pready_o, pslverr_o, prog_port_block_o, flash_rd_o, busy_o, write_done_o;
  logic [13:0] flash_data_i;
  int err_total = 0, check_count = 0, cyc = 0;
  nvac_ctrl #(.WRITE_CYC(8)) dut (.mclk_i(mclk_i), .reset_i(reset_i), .por_i(por_i),
    .ext_reset_i(ext_reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .prog_port_req_i(prog_port_req_i),
    .prog_port_block_o(prog_port_block_o), .flash_addr_o(flash_addr_o),
    .flash_rd_o(flash_rd_o), .flash_data_i(flash_data_i), .busy_o(busy_o),
    .write_done_o(write_done_o));
  nvac_flash_model u_flash (.mclk_i(mclk_i), .rd_i(flash_rd_o), .addr_i(flash_addr_o),
    .data_o(flash_data_i));
  initial forever #5 mclk_i = ~mclk_i;
  task results;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // A hang ends the run after about thirteen times the expected length
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      results();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rdv = prdata_o;
    slv = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdv);
  endtask
  task wseq(input logic [31:0] a, input logic [31:0] d, input logic [31:0] k);
    apb(1'b1, 12'h008, a);
    apb(1'b1, 12'h000, d);
    apb(1'b1, 12'h010, k & ~32'h2);
    apb(1'b1, 12'h014, 32'h55);
    apb(1'b1, 12'h014, 32'hAA);
    apb(1'b1, 12'h010, k);
  endtask
  task busy_is(input logic e);
    @(posedge mclk_i);
    chk("busy", {31'h0, e}, {31'h0, busy_o});
  endtask
  task idle(input int n);
    int k;
    k = 0;
    @(posedge mclk_i);
    while (busy_o === 1'b1 && k < 40)
    begin
      k++;
      @(posedge mclk_i);
    end
    chk("busy end", 32'h0, {31'h0, busy_o});
    if (n > 0)
      chk("write cycles", n, k);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    por_i <= 1'b0;
    for (int a = 0; a < 32; a += 4) rd(a[11:0], 32'h0, "reset value");
    rd(12'h020, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, slv});
    apb(1'b1, 12'h004, 32'hFF);
    rd(12'h004, 32'h3F, "data high");
    apb(1'b1, 12'h00C, 32'hFF);
    rd(12'h00C, 32'h0F, "address high");
    apb(1'b1, 12'h014, 32'hFF);
    rd(12'h014, 32'h0, "unlock port");
    wseq(32'hFF, 32'hA5, 32'h06);
    busy_is(1'b1);
    apb(1'b1, 12'h008, 32'h33);
    idle(0);
    rd(12'h008, 32'hFF, "address during write");
    rd(12'h018, 32'h1, "done flag");
    apb(1'b1, 12'h018, 32'h0);
    rd(12'h018, 32'h0, "done cleared");
    wseq(32'h00, 32'h5A, 32'h06);
    idle(8);
    apb(1'b1, 12'h008, 32'hFF);
    apb(1'b1, 12'h010, 32'h05);
    rd(12'h000, 32'hA5, "stored byte");
    apb(1'b1, 12'h000, 32'h11);
    apb(1'b1, 12'h010, 32'h06);
    busy_is(1'b0);
    wseq(32'h00, 32'h22, 32'h02);
    busy_is(1'b0);
    wseq(32'h00, 32'h33, 32'h86);
    busy_is(1'b0);
    apb(1'b1, 12'h010, 32'h05);
    rd(12'h000, 32'h5A, "kept byte");
    apb(1'b1, 12'h00C, 32'h0A);
    apb(1'b1, 12'h008, 32'hBC);
    apb(1'b1, 12'h010, 32'h81);
    rd(12'h000, 32'hC7, "word low");
    rd(12'h004, 32'h38, "word high");
    wseq(32'h01, 32'h44, 32'h06);
    ext_reset_i <= 1'b1;
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    ext_reset_i <= 1'b0;
    apb(1'b0, 12'h010, 32'h0);
    chk("aborted", 32'h08, rdv & 32'h0A);
    prog_port_req_i <= 1'b1;
    @(posedge mclk_i);
    chk("open", 32'h0, {31'h0, prog_port_block_o});
    apb(1'b1, 12'h01C, 32'h1);
    @(posedge mclk_i);
    chk("blocked", 32'h1, {31'h0, prog_port_block_o});
    results();
  end
endmodule
`default_nettype wire
